/* File: src/srw_pkg.sv */
// Package: register map, field layout and timing constants of the serial receive wakeup block
package srw_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_BAUD   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DATA   = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_WAKE_SEL    = 0;
  localparam int CTRL_IDLE_START  = 1;
  localparam int CTRL_SINGLE_WIRE = 2;
  localparam int CTRL_RX_EN       = 3;
  localparam int CTRL_TX_EN       = 4;
  localparam int CTRL_STANDBY     = 5;
  localparam int STAT_DATA_FULL   = 0;
  localparam int STAT_IDLE        = 1;
  localparam int STAT_TX_BUSY     = 2;
  localparam int STAT_IDLE_LINE   = 3;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [5:0]  CTRL_RST      = 6'h18;
  localparam logic [15:0] BAUD_DIV_RST  = 16'h0001;
  localparam int          OVERSAMPLE    = 16;
  localparam int          HALF_BIT      = OVERSAMPLE / 2;
  localparam int          DATA_BITS     = 8;
  localparam int          IDLE_BITS     = 10;
  localparam int          IDLE_TICKS    = IDLE_BITS * OVERSAMPLE;
  localparam int          FRAME_BITS    = DATA_BITS + 2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic receiver_standby_flag;
    logic tx_en;
    logic rx_en;
    logic single_wire;
    logic idle_count_start_select;
    logic wake_sel;
  } srw_ctrl_t;

  typedef struct packed {
    logic                 msb_mark;
    logic                 frame_done;
    logic                 idle_pulse;
    logic                 idle_level;
    logic [DATA_BITS-1:0] data;
  } srw_rx_evt_t;

endpackage

/* File: src/srw_rx_frame.sv */
// Frame receiver with idle character detection, driven by a 16x sample enable
`timescale 1ns/1ps
module srw_rx_frame (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                tick,
  input  wire logic                rx,
  input  wire logic                rx_en,
  input  wire logic                idle_count_start_select,
  output srw_pkg::srw_rx_evt_t     evt
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} srw_rx_state_t;

  srw_rx_state_t state;
  logic [3:0]    sub;
  logic [2:0]    bitn;
  logic [7:0]    shreg;
  logic [7:0]    idle_ticks;
  logic          count_ok;
  logic          msb_mark;
  logic          frame_done;
  logic          idle_pulse;
  logic          idle_level;

  localparam logic [3:0] SUB_LAST  = 4'(srw_pkg::OVERSAMPLE - 1);
  localparam logic [3:0] SUB_HALF  = 4'(srw_pkg::HALF_BIT - 1);
  localparam logic [2:0] BIT_LAST  = 3'(srw_pkg::DATA_BITS - 1);
  localparam logic [7:0] IDLE_FULL = 8'(srw_pkg::IDLE_TICKS);

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= RX_IDLE;
      sub   <= 4'h0;
      bitn  <= 3'h0;
      shreg <= 8'h00;
    end else if (!rx_en) begin
      state <= RX_IDLE;
    end else if (tick) begin
      unique case (state)
        RX_IDLE: begin
          sub <= 4'h0;
          if (!rx) begin
            state <= RX_START;
          end
        end
        RX_START: begin
          sub <= sub + 4'h1;
          if (sub == SUB_HALF) begin
            // False start: glitch shorter than half a bit
            state <= rx ? RX_IDLE : RX_DATA;
            sub   <= 4'h0;
            bitn  <= 3'h0;
          end
        end
        RX_DATA: begin
          sub <= sub + 4'h1;
          if (sub == SUB_LAST) begin
            shreg <= {rx, shreg[7:1]};
            bitn  <= bitn + 3'h1;
            if (bitn == BIT_LAST) begin
              state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          sub <= sub + 4'h1;
          if (sub == SUB_LAST) begin
            state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Event pulses
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msb_mark   <= 1'b0;
      frame_done <= 1'b0;
    end else begin
      // Msb seen at its bit centre, well before the stop bit
      msb_mark   <= rx_en && tick && state == RX_DATA && sub == SUB_LAST && bitn == BIT_LAST && rx;
      // Frames with a broken stop bit are dropped
      frame_done <= rx_en && tick && state == RX_STOP && sub == SUB_LAST && rx;
    end
  end

  // One driver for the whole carrier
  assign evt = {msb_mark, frame_done, idle_pulse, idle_level, shreg};

  // ----------------------------------------------------------------
  // Idle character counter
  // ----------------------------------------------------------------
  // Counting starts after the start bit, or only after the stop bit
  assign count_ok = (state == RX_IDLE) || (!idle_count_start_select && state != RX_START);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_ticks <= 8'h00;
      idle_pulse <= 1'b0;
      idle_level <= 1'b0;
    end else begin
      idle_pulse <= 1'b0;
      if (!rx_en || !rx) begin
        idle_ticks <= 8'h00;
      end else if (tick && count_ok && idle_ticks != IDLE_FULL) begin
        idle_ticks <= idle_ticks + 8'h01;
        idle_pulse <= (idle_ticks == IDLE_FULL - 8'h01);
      end
      idle_level <= rx_en && rx && (idle_ticks == IDLE_FULL);
    end
  end

  idle_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    idle_count_start_select && rx_en && rx && state == RX_DATA |=> idle_ticks == $past(idle_ticks))
    else $error("idle count advanced inside a frame");

endmodule // srw_rx_frame

/* File: src/srw_top.sv */
// Top: AHB-Lite registers, receiver standby and wakeup, transmitter, single-wire pin routing
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module srw_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        rxd_in,
  input  wire logic        txd_in,
  output logic             txd_out,
  output logic             txd_oe
);

  srw_pkg::srw_ctrl_t   ctrl;
  srw_pkg::srw_rx_evt_t rx_evt;
  logic [15:0]          baud_div;
  logic [15:0]          baud_cnt;
  logic                 tick;
  logic                 rx_data_full_flag;
  logic                 idle_flag;
  logic                 idle_armed;
  logic [7:0]           rx_data;
  logic                 wr_pend;
  logic [7:0]           wr_addr;
  logic                 addr_ok;
  logic                 ctrl_wr;
  logic                 data_rd;
  logic                 wake;
  logic                 rx_line;
  logic [1:0]           pin_raw;
  logic [1:0]           pin_s1;
  logic [1:0]           pin_s2;
  logic [1:0]           pin_s3;
  logic [1:0]           pin_filt;
  logic [9:0]           tx_sh;
  logic [3:0]           tx_bits;
  logic [3:0]           tx_sub;
  logic                 tx_active;

  // ----------------------------------------------------------------
  // Pin synchronisers: a change counts once stages two and three agree
  // ----------------------------------------------------------------
  assign pin_raw = {txd_in, rxd_in};

  for (genvar i = 0; i < 2; i++) begin : g_pin
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pin_s1[i]   <= 1'b1;
        pin_s2[i]   <= 1'b1;
        pin_s3[i]   <= 1'b1;
        pin_filt[i] <= 1'b1;
      end else begin
        pin_s1[i] <= pin_raw[i];
        pin_s2[i] <= pin_s1[i];
        pin_s3[i] <= pin_s2[i];
        if (pin_s2[i] == pin_s3[i]) begin
          pin_filt[i] <= pin_s3[i];
        end
      end
    end
  end
  // Receive pin is cut off entirely in single-wire use
  assign rx_line = ctrl.single_wire ? pin_filt[1] : pin_filt[0];

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait state, always OKAY
  // ----------------------------------------------------------------
  assign addr_ok = hsel && hready && htrans[1];
  assign data_rd = addr_ok && !hwrite && haddr == srw_pkg::ADDR_DATA;
  assign ctrl_wr = wr_pend && wr_addr == srw_pkg::ADDR_CTRL;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr <= haddr;
      end
      if (addr_ok && !hwrite) begin
        unique case (haddr)
          srw_pkg::ADDR_CTRL:   hrdata <= {26'h0, ctrl};
          srw_pkg::ADDR_BAUD:   hrdata <= {16'h0, baud_div};
          srw_pkg::ADDR_STATUS: hrdata <= {28'h0, rx_evt.idle_level, tx_active, idle_flag, rx_data_full_flag};
          srw_pkg::ADDR_DATA:   hrdata <= {24'h0, rx_data};
          default:              hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and baud registers
  // ----------------------------------------------------------------
  // Hardware wakes only from standby; software writes win so a set is never lost
  assign wake = ctrl.receiver_standby_flag &&
                (ctrl.wake_sel ? rx_evt.msb_mark : rx_evt.idle_level);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= srw_pkg::CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl <= hwdata[5:0];
    end else if (wake) begin
      ctrl.receiver_standby_flag <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_div <= srw_pkg::BAUD_DIV_RST;
    end else if (wr_pend && wr_addr == srw_pkg::ADDR_BAUD) begin
      baud_div <= hwdata[15:0];
    end
  end

  // 16x sample enable; a divisor of zero acts as one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else if (baud_cnt + 16'h0001 >= baud_div) begin
      baud_cnt <= 16'h0000;
      tick     <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Receiver and receive flags
  // ----------------------------------------------------------------
  srw_rx_frame u_rx (
    .hclk                    (hclk),
    .hresetn                 (hresetn),
    .tick                    (tick),
    .rx                      (rx_line),
    .rx_en                   (ctrl.rx_en),
    .idle_count_start_select (ctrl.idle_count_start_select),
    .evt                     (rx_evt)
  );

  // Data-full: set beats the clearing read in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_data_full_flag <= 1'b0;
      rx_data           <= 8'h00;
    end else if (rx_evt.frame_done && !ctrl.receiver_standby_flag) begin
      rx_data_full_flag <= 1'b1;
      rx_data           <= rx_evt.data;
    end else if (data_rd) begin
      rx_data_full_flag <= 1'b0;
    end
  end

  // Idle flag only after real traffic, never for the waking idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_flag  <= 1'b0;
      idle_armed <= 1'b0;
    end else begin
      if (rx_evt.frame_done && !ctrl.receiver_standby_flag) begin
        idle_armed <= 1'b1;
      end else if (rx_evt.idle_pulse) begin
        idle_armed <= 1'b0;
      end
      if (rx_evt.idle_pulse && idle_armed && !ctrl.receiver_standby_flag) begin
        idle_flag <= 1'b1;
      end else if (wr_pend && wr_addr == srw_pkg::ADDR_STATUS && hwdata[srw_pkg::STAT_IDLE]) begin
        idle_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_sh     <= 10'h3FF;
      tx_bits   <= 4'h0;
      tx_sub    <= 4'h0;
      tx_active <= 1'b0;
    end else if (!tx_active) begin
      // A data write while busy is dropped; poll the busy bit first
      if (wr_pend && wr_addr == srw_pkg::ADDR_DATA && ctrl.tx_en) begin
        tx_sh     <= {1'b1, hwdata[7:0], 1'b0};
        tx_bits   <= 4'h0;
        tx_sub    <= 4'h0;
        tx_active <= 1'b1;
      end
    end else if (tick) begin
      tx_sub <= tx_sub + 4'h1;
      if (tx_sub == 4'(srw_pkg::OVERSAMPLE - 1)) begin
        tx_sh   <= {1'b1, tx_sh[9:1]};
        tx_bits <= tx_bits + 4'h1;
        if (tx_bits == 4'(srw_pkg::FRAME_BITS - 1)) begin
          tx_active <= 1'b0;
        end
      end
    end
  end

  // Shared wire is released whenever nothing is being sent in single-wire use; otherwise the pin is always driven
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_out <= 1'b1;
      txd_oe  <= 1'b0;
    end else begin
      txd_out <= tx_active ? tx_sh[0] : 1'b1;
      txd_oe  <= tx_active || !ctrl.single_wire;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  wake_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl.receiver_standby_flag && !ctrl.wake_sel && rx_evt.idle_level && !ctrl_wr
    |=> !ctrl.receiver_standby_flag)
    else $error("idle line did not end standby");

  wake_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl.receiver_standby_flag && ctrl.wake_sel && rx_evt.msb_mark && !ctrl_wr
    |=> !ctrl.receiver_standby_flag)
    else $error("address frame did not end standby");

  mode_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl.receiver_standby_flag && ctrl.wake_sel && rx_evt.idle_level && !rx_evt.msb_mark && !ctrl_wr
    |=> ctrl.receiver_standby_flag)
    else $error("idle line woke address-mark receiver");

  standby_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl.receiver_standby_flag && !ctrl.wake_sel && !rx_evt.idle_level && !ctrl_wr
    |=> ctrl.receiver_standby_flag)
    else $error("standby left without idle");

  addr_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl.receiver_standby_flag && ctrl.wake_sel && !rx_evt.msb_mark && !ctrl_wr
    |=> ctrl.receiver_standby_flag)
    else $error("standby left without address frame");

  wake_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_evt.idle_pulse && ctrl.receiver_standby_flag && !idle_flag |=> !idle_flag)
    else $error("waking idle set idle flag");

  addr_data_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl.wake_sel && ctrl.receiver_standby_flag && rx_evt.msb_mark && !ctrl_wr
    ##1 (!ctrl_wr)[*1] ##[1:300] rx_evt.frame_done |=> rx_data_full_flag)
    else $error("address frame did not set data-full");

  standby_mute_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_evt.frame_done && ctrl.receiver_standby_flag && !rx_data_full_flag |=> !rx_data_full_flag && rx_data == $past(rx_data))
    else $error("frame in standby reached software");

  idle_early_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_wr && hwdata[srw_pkg::CTRL_STANDBY] && !hwdata[srw_pkg::CTRL_WAKE_SEL] && rx_evt.idle_level
    ##1 rx_evt.idle_level |=> !ctrl.receiver_standby_flag)
    else $error("standby on idle line did not wake");

  wire_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl.single_wire && !tx_active |=> !txd_oe)
    else $error("single-wire pin driven while idle");

  wire_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl.single_wire && tx_active |=> txd_oe)
    else $error("single-wire pin not driven while sending");

  data_full_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_evt.frame_done && !ctrl.receiver_standby_flag |=> rx_data_full_flag && rx_data == $past(rx_evt.data))
    else $error("accepted frame did not set data-full");

  idle_flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_evt.idle_pulse && idle_armed && !ctrl.receiver_standby_flag |=> idle_flag)
    else $error("idle after traffic did not set idle flag");

endmodule // srw_top

/* File: verif/srw_node_model.sv */
// Partner model: another serial node driving the shared line, 8N1, LSB first
`timescale 1ns/1ps
module srw_node_model #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic hclk,
  output logic      line
);
  // Line has a pull-up, so a released line reads high
  initial line = 1'b1;

  // ------------------------------------------------------------------
  // Frame sender
  // ------------------------------------------------------------------
  // Message spacing and msb use are left to the caller
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= frame[i];
      repeat (BIT_CYCLES) @(posedge hclk);
    end
  endtask
endmodule // srw_node_model

/* File: verif/tb_serial_rx_wakeup_control.sv */
// Testbench: register access, wakeup modes and single-wire routing of the serial receive block
`timescale 1ns/1ps
module tb_serial_rx_wakeup_control;
  logic        hclk      = 1'b0;
  logic        hresetn   = 1'b0;
  logic        hsel      = 1'b0;
  logic [7:0]  haddr     = 8'h00;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0;
  logic        sw_mode   = 1'b0;
  logic        rd_pend   = 1'b0;
  logic        hreadyout, hresp, txd_out, txd_oe, node_line;
  logic [31:0] hrdata, m;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  logic [7:0]  b;
  int          n_errors  = 0;
  int          checks    = 0;

  always #2.5 hclk = ~hclk;

  // Receive pin held low in single-wire: the receiver reads the transmit pin then, so this level is never seen
  wire rxd_line = sw_mode ? 1'b0 : node_line;
  wire txd_line = txd_oe ? txd_out : (sw_mode ? node_line : 1'b1);

  srw_top u_srw_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rxd_in(rxd_line),
    .txd_in(txd_line), .txd_out(txd_out), .txd_oe(txd_oe)
  );

  srw_node_model u_srw_node_model (.hclk(hclk), .line(node_line));

  // ------------------------------------------------------------------
  // Bus tasks and comparison
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
    mask_q.push_back(msk);
    exp_q.push_back(e & msk);
    xfer(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] ctrl(input logic ws, input logic idle_start, input logic sw, input logic sb);
    ctrl = 32'h0;
    ctrl[srw_pkg::CTRL_WAKE_SEL]    = ws;
    ctrl[srw_pkg::CTRL_IDLE_START]  = idle_start;
    ctrl[srw_pkg::CTRL_SINGLE_WIRE] = sw;
    ctrl[srw_pkg::CTRL_RX_EN]       = 1'b1;
    ctrl[srw_pkg::CTRL_TX_EN]       = 1'b1;
    ctrl[srw_pkg::CTRL_STANDBY]     = sb;
  endfunction

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic complete_run();
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Read data monitor
  // ------------------------------------------------------------------
  always @(posedge hclk) begin
    if (hresetn && hreadyout === 1'b1) begin
      if (rd_pend) begin
        m = mask_q.pop_front();
        chk(hrdata & m, exp_q.pop_front());
        chk({31'h0, hresp}, 32'h0000_0000);
      end
      rd_pend = hsel && htrans[1] && !hwrite;
    end
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(32));
    wait_cyc(5);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(srw_pkg::ADDR_CTRL, 32'hFFFFFFFF, {26'h0, srw_pkg::CTRL_RST});
    rd(srw_pkg::ADDR_BAUD, 32'hFFFFFFFF, 32'h00000001);
    rd(srw_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'h00000000);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'hFFFFFFFF, 32'h00000000);
    for (int st = 0; st < 2; st++) begin
      wr(srw_pkg::ADDR_CTRL, ctrl(1'b0, st[0], 1'b0, 1'b0));
      wait_cyc(200);
      // All-ones data lets the count start point show at the idle level
      u_srw_node_model.send_byte(8'hFF);
      wait_cyc(60);
      rd(srw_pkg::ADDR_STATUS, 32'h00000008, {28'h0, ~st[0], 3'h0});
      rd(srw_pkg::ADDR_DATA, 32'h000000FF, 32'h000000FF);
      wait_cyc(200);
      rd(srw_pkg::ADDR_STATUS, 32'h0000000B, 32'h0000000A);
      wr(srw_pkg::ADDR_STATUS, 32'h00000002);
    end
    wr(srw_pkg::ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b1));
    wait_cyc(4);
    rd(srw_pkg::ADDR_CTRL, 32'hFFFFFFFF, ctrl(1'b0, 1'b0, 1'b0, 1'b0));
    // One message of three frames back to back, no idle inside
    fork
      for (int i = 0; i < 3; i++) u_srw_node_model.send_byte(8'($urandom()));
    join_none
    wait_cyc(10);
    wr(srw_pkg::ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b1));
    wait_cyc(280);
    rd(srw_pkg::ADDR_CTRL, 32'hFFFFFFFF, ctrl(1'b0, 1'b0, 1'b0, 1'b1));
    rd(srw_pkg::ADDR_STATUS, 32'h00000003, 32'h00000000);
    wait fork;
    wait_cyc(200);
    rd(srw_pkg::ADDR_CTRL, 32'hFFFFFFFF, ctrl(1'b0, 1'b0, 1'b0, 1'b0));
    rd(srw_pkg::ADDR_STATUS, 32'h00000003, 32'h00000000);
    wr(srw_pkg::ADDR_CTRL, ctrl(1'b1, 1'b0, 1'b0, 1'b1));
    for (int i = 0; i < 2; i++) begin
      u_srw_node_model.send_byte(8'($urandom()) & 8'h7F);
      wait_cyc(200);
    end
    rd(srw_pkg::ADDR_CTRL, 32'hFFFFFFFF, ctrl(1'b1, 1'b0, 1'b0, 1'b1));
    rd(srw_pkg::ADDR_STATUS, 32'h00000003, 32'h00000000);
    b = 8'($urandom()) | 8'h80;
    fork
      u_srw_node_model.send_byte(b);
    join_none
    // Read lands after the msb centre but ahead of the stop bit centre
    wait_cyc(146);
    rd(srw_pkg::ADDR_CTRL, 32'hFFFFFFFF, ctrl(1'b1, 1'b0, 1'b0, 1'b0));
    wait fork;
    wait_cyc(20);
    rd(srw_pkg::ADDR_STATUS, 32'h00000001, 32'h00000001);
    rd(srw_pkg::ADDR_DATA, 32'h000000FF, {24'h0, b});
    wr(srw_pkg::ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b1, 1'b0));
    sw_mode <= 1'b1;
    wait_cyc(200);
    b = 8'($urandom());
    u_srw_node_model.send_byte(b);
    wait_cyc(20);
    rd(srw_pkg::ADDR_DATA, 32'h000000FF, {24'h0, b});
    b = 8'($urandom());
    wr(srw_pkg::ADDR_DATA, {24'h0, b});
    wait_cyc(200);
    rd(srw_pkg::ADDR_DATA, 32'h000000FF, {24'h0, b});
    wait_cyc(4);
    complete_run();
  end

  initial begin
    wait_cyc(20000);
    n_errors++;
    complete_run();
  end
endmodule // tb_serial_rx_wakeup_control
